// ---- hdl/lite_ar_pkg.sv ----
package lite_ar_pkg;

    // ------------------------------------------------------------
    // buffer geometry
    // ------------------------------------------------------------
    localparam int ADDR_W     = 32;
    localparam int PROT_W     = 4;
    localparam int FIFO_DEPTH = 16;
    localparam int THR_W      = $clog2(FIFO_DEPTH);
    localparam int CNT_W      = THR_W + 1;

    // threshold values the controller presents across reset
    localparam logic [THR_W-1:0] AF_THR_RST = 4'hc;
    localparam logic [THR_W-1:0] AE_THR_RST = 4'h2;

    // ------------------------------------------------------------
    // controller register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_ADDR     = 8'h00;
    localparam logic [7:0] REG_PROT     = 8'h04;
    localparam logic [7:0] REG_PUSH     = 8'h08;
    localparam logic [7:0] REG_SINK     = 8'h0c;
    localparam logic [7:0] REG_RX_ADDR  = 8'h10;
    localparam logic [7:0] REG_RX_PROT  = 8'h14;
    localparam logic [7:0] REG_STATUS   = 8'h18;
    localparam logic [7:0] REG_COUNT    = 8'h1c;
    localparam logic [7:0] REG_AF_THR   = 8'h20;
    localparam logic [7:0] REG_AE_THR   = 8'h24;
    localparam logic [7:0] REG_IRQ_STAT = 8'h28;
    localparam logic [7:0] REG_IRQ_CLR  = 8'h2c;
    localparam logic [7:0] REG_IRQ_EN   = 8'h30;

    // ------------------------------------------------------------
    // interrupt bit positions
    // ------------------------------------------------------------
    localparam int IRQ_W       = 4;
    localparam int IRQ_PUSHED  = 0;
    localparam int IRQ_RECVD   = 1;
    localparam int IRQ_AF_RISE = 2;
    localparam int IRQ_UFLOW   = 3;

    // status register bit positions
    localparam int ST_PENDING = 0;
    localparam int ST_AF      = 1;
    localparam int ST_AE      = 2;
    localparam int ST_SINK    = 3;

endpackage

// ---- hdl/lite_ar_if.sv ----
`timescale 1ns/100ps
interface lite_ar_if
    import lite_ar_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int TW = THR_W
);
    // upstream side: master pushes into the buffer
    logic            s_arvalid;
    logic            s_arready;
    logic [AW-1:0]   s_araddr;
    logic [PROT_W-1:0] s_arprot;
    // downstream side: buffer replays to the slave
    logic            m_arvalid;
    logic            m_arready;
    logic [AW-1:0]   m_araddr;
    logic [PROT_W-1:0] m_arprot;
    // sideband
    logic [TW-1:0]   af_threshold;
    logic [TW-1:0]   ae_threshold;
    logic [TW:0]     wr_count;
    logic [TW:0]     rd_count;
    logic [TW:0]     data_count;
    logic            almost_full;
    logic            almost_empty;
    logic            underflow;

    modport dev (
        input  s_arvalid, s_araddr, s_arprot, m_arready, af_threshold, ae_threshold,
        output s_arready, m_arvalid, m_araddr, m_arprot,
        output wr_count, rd_count, data_count, almost_full, almost_empty, underflow
    );

    modport far (
        output s_arvalid, s_araddr, s_arprot, m_arready, af_threshold, ae_threshold,
        input  s_arready, m_arvalid, m_araddr, m_arprot,
        input  wr_count, rd_count, data_count, almost_full, almost_empty, underflow
    );
endinterface

// ---- hdl/lite_ar_fifo.sv ----
// Notes on behaviour
// - write count may underreport stored words for one cycle after a write
// - accepted write shows in count next edge
// - underflow flags a read refused while empty
// - refused read leaves buffer state untouched
// - underflow may stay constantly low here
// - read count may overreport readable words for one cycle after a read
// - accepted read shows in count next edge
// - common count of stored words, log2+1 wide
// - almost-full high while count at/above threshold
// - almost-empty high while count at/below threshold
// - thresholds sampled across reset, held by surroundings
// - address and protection stored and replayed unchanged
// - entry written on upstream valid and ready
// - upstream holds address and valid until ready
// - downstream entry held until slave ready, popped
`timescale 1ns/100ps
module lite_ar_fifo
    import lite_ar_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int AW    = ADDR_W
)(
    input  wire logic clk_sys_i,
    input  wire logic arst_n_i,
    lite_ar_if.dev    bus
);

    // ------------------------------------------------------------
    // derived widths
    // ------------------------------------------------------------
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam int EW = AW + PROT_W;

    localparam logic [PW-1:0] PTR_LAST  = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL  = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_EMPTY = '0;
    localparam logic [PW-1:0] PTR_ONE   = PW'(1);
    localparam logic [CW-1:0] CNT_ONE   = CW'(1);

    typedef logic [EW-1:0] entry_t;

    typedef struct packed {
        entry_t [DEPTH-1:0] mem;
        logic [PW-1:0]      wr_ptr;
        logic [PW-1:0]      rd_ptr;
        logic [CW-1:0]      count;
        logic [CW-1:0]      wr_count;
        logic [CW-1:0]      rd_count;
        logic [PW-1:0]      af_thr;
        logic [PW-1:0]      ae_thr;
        logic               thr_loaded;
        logic               s_ready;
        logic               m_valid;
        entry_t             head;
        logic               af;
        logic               ae;
        logic               uflow;
    } fifo_state_t;

    fifo_state_t st_q;
    fifo_state_t st_d;

    // ------------------------------------------------------------
    // reset state
    // ------------------------------------------------------------
    // empty and ready, almost-empty set; default thresholds only
    // until the first edge out of reset catches the presented ones
    localparam fifo_state_t ST_RST = '{
        mem:        '0,
        wr_ptr:     '0,
        rd_ptr:     '0,
        count:      '0,
        wr_count:   '0,
        rd_count:   '0,
        af_thr:     PW'(AF_THR_RST),
        ae_thr:     PW'(AE_THR_RST),
        thr_loaded: 1'b0,
        s_ready:    1'b1,
        m_valid:    1'b0,
        head:       '0,
        af:         1'b0,
        ae:         1'b1,
        uflow:      1'b0
    };

    logic push;
    logic pop;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;

        push = bus.s_arvalid & st_q.s_ready;
        pop  = st_q.m_valid & bus.m_arready;

        // --------------------------------------------------------
        // thresholds
        // --------------------------------------------------------
        // async-reset flops take only constants, so the values held
        // steady across reset are caught at the first edge out of it
        // thresholds caught at first edge after release
        if (!st_q.thr_loaded) begin
            st_d.thr_loaded = 1'b1;
            st_d.af_thr     = bus.af_threshold;
            st_d.ae_thr     = bus.ae_threshold;
        end

        // --------------------------------------------------------
        // write side
        // --------------------------------------------------------
        // pack address with protection
        if (push) begin
            st_d.mem[st_q.wr_ptr] = {bus.s_arprot, bus.s_araddr};
            if (st_q.wr_ptr == PTR_LAST) begin
                st_d.wr_ptr = '0;
            end else begin
                st_d.wr_ptr = st_q.wr_ptr + PTR_ONE;
            end
        end

        // --------------------------------------------------------
        // read side
        // --------------------------------------------------------
        // pop only with a held entry, so empty reads touch nothing
        if (pop) begin
            if (st_q.rd_ptr == PTR_LAST) begin
                st_d.rd_ptr = '0;
            end else begin
                st_d.rd_ptr = st_q.rd_ptr + PTR_ONE;
            end
        end

        // --------------------------------------------------------
        // counts
        // --------------------------------------------------------
        // common count tracks stored words exactly
        if (push && !pop) begin
            st_d.count = st_q.count + CNT_ONE;
        end else if (pop && !push) begin
            st_d.count = st_q.count - CNT_ONE;
        end

        // side counts lag the common count by one edge
        st_d.wr_count = st_q.count;
        // same lag on the read side
        st_d.rd_count = st_q.count;

        // --------------------------------------------------------
        // handshakes, head and flags
        // --------------------------------------------------------
        // ready only while a slot is free
        st_d.s_ready = (st_d.count != CNT_FULL);
        // valid only while an entry is held
        st_d.m_valid = (st_d.count != CNT_EMPTY);
        // head follows the new read pointer; a write into an empty
        // buffer lands in mem_d, so it forwards with no extra path
        // head only moves after a pop or a write into an empty buffer, so it stays stable
        st_d.head = st_d.mem[st_d.rd_ptr];

        st_d.af = (st_d.count >= {1'b0, st_d.af_thr});
        st_d.ae = (st_d.count <= {1'b0, st_d.ae_thr});

        // a read can never be taken while empty, so the
        // refused-read report never fires
        // held low
        st_d.uflow = 1'b0;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // all counts and flags on the single system clock
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------
    assign bus.s_arready = st_q.s_ready;
    assign bus.m_arvalid = st_q.m_valid;
    assign bus.m_araddr  = st_q.head[AW-1:0];
    assign bus.m_arprot  = st_q.head[EW-1:AW];

    // ------------------------------------------------------------
    // sideband counts and flags
    // ------------------------------------------------------------
    // lagging write count may only underreport for the
    // one cycle after a write, pops make it safely high
    assign bus.wr_count  = st_q.wr_count;
    // lagging read count may only overreport for the
    // one cycle after a read, pushes make it safely low
    assign bus.rd_count  = st_q.rd_count;
    assign bus.data_count = st_q.count;

    assign bus.almost_full  = st_q.af;
    assign bus.almost_empty = st_q.ae;
    assign bus.underflow    = st_q.uflow;

endmodule

// ---- hdl/lite_ar_ctrl.sv ----
`timescale 1ns/100ps
module lite_ar_ctrl
    import lite_ar_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int TW = THR_W
)(
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    output logic             irq_o,
    lite_ar_if.far           bus
);

    typedef struct packed {
        logic [AW-1:0]     addr;
        logic [PROT_W-1:0] prot;
        logic              up_valid;
        logic              sink_en;
        logic [AW-1:0]     rx_addr;
        logic [PROT_W-1:0] rx_prot;
        logic [TW-1:0]     af_thr;
        logic [TW-1:0]     ae_thr;
        logic              af_prev;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_en;
        logic              irq;
        logic [31:0]       rdata;
    } ctrl_state_t;

    ctrl_state_t st_q;
    ctrl_state_t st_d;

    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic             pushed;
    logic             recvd;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d   = st_q;
        // push taken on valid and ready
        pushed = st_q.up_valid & bus.s_arready;
        // entry taken on valid and our ready
        recvd  = bus.m_arvalid & st_q.sink_en;
        clr    = '0;

        if (pushed) begin
            st_d.up_valid = 1'b0;
        end
        if (recvd) begin
            st_d.rx_addr = bus.m_araddr;
            st_d.rx_prot = bus.m_arprot;
        end

        if (reg_wr_i) begin
            case (reg_addr_i)
                // payload frozen while a push is pending
                REG_ADDR: if (!st_q.up_valid) st_d.addr = reg_wdata_i[AW-1:0];
                REG_PROT: if (!st_q.up_valid) st_d.prot = reg_wdata_i[PROT_W-1:0];
                REG_PUSH: st_d.up_valid = 1'b1;
                REG_SINK: st_d.sink_en = reg_wdata_i[0];
                // readback copy; a reset restores the defaults
                REG_AF_THR: st_d.af_thr = reg_wdata_i[TW-1:0];
                REG_AE_THR: st_d.ae_thr = reg_wdata_i[TW-1:0];
                REG_IRQ_CLR: clr = reg_wdata_i[IRQ_W-1:0];
                REG_IRQ_EN: st_d.irq_en = reg_wdata_i[IRQ_W-1:0];
                default: ;
            endcase
        end

        st_d.rdata = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                REG_ADDR:     st_d.rdata = 32'(st_q.addr);
                REG_PROT:     st_d.rdata = 32'(st_q.prot);
                REG_SINK:     st_d.rdata = 32'(st_q.sink_en);
                REG_RX_ADDR:  st_d.rdata = 32'(st_q.rx_addr);
                REG_RX_PROT:  st_d.rdata = 32'(st_q.rx_prot);
                REG_STATUS: begin
                    st_d.rdata[ST_PENDING] = st_q.up_valid;
                    st_d.rdata[ST_AF]      = bus.almost_full;
                    st_d.rdata[ST_AE]      = bus.almost_empty;
                    st_d.rdata[ST_SINK]    = st_q.sink_en;
                end
                REG_COUNT:    st_d.rdata = 32'(bus.data_count);
                REG_AF_THR:   st_d.rdata = 32'(st_q.af_thr);
                REG_AE_THR:   st_d.rdata = 32'(st_q.ae_thr);
                REG_IRQ_STAT: st_d.rdata = 32'(st_q.irq_stat);
                REG_IRQ_EN:   st_d.rdata = 32'(st_q.irq_en);
                default:      st_d.rdata = '0;
            endcase
        end

        ev              = '0;
        ev[IRQ_PUSHED]  = pushed;
        ev[IRQ_RECVD]   = recvd;
        ev[IRQ_AF_RISE] = bus.almost_full & ~st_q.af_prev;
        ev[IRQ_UFLOW]   = bus.underflow;
        st_d.af_prev    = bus.almost_full;
        // set wins over a clear in the same cycle
        st_d.irq_stat   = (st_q.irq_stat & ~clr) | ev;
        st_d.irq        = |(st_d.irq_stat & st_d.irq_en);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q        <= '0;
            st_q.af_thr <= AF_THR_RST;
            st_q.ae_thr <= AE_THR_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus.s_arvalid    = st_q.up_valid;
    assign bus.s_araddr     = st_q.addr;
    assign bus.s_arprot     = st_q.prot;
    assign bus.m_arready    = st_q.sink_en;
    // thresholds stand steady from flops across reset
    assign bus.af_threshold = st_q.af_thr;
    assign bus.ae_threshold = st_q.ae_thr;
    assign reg_rdata_o      = st_q.rdata;
    assign irq_o            = st_q.irq;

endmodule

// ---- testbench/lite_ar_asserts.sv ----
`timescale 1ns/100ps
module lite_ar_asserts
    import lite_ar_pkg::*;
(
    input wire logic              clk_sys_i,
    input wire logic              arst_n_i,
    input wire logic              s_arvalid,
    input wire logic              s_arready,
    input wire logic [ADDR_W-1:0] s_araddr,
    input wire logic [PROT_W-1:0] s_arprot,
    input wire logic              m_arvalid,
    input wire logic              m_arready,
    input wire logic [ADDR_W-1:0] m_araddr,
    input wire logic [PROT_W-1:0] m_arprot,
    input wire logic [THR_W-1:0]  af_threshold,
    input wire logic [THR_W-1:0]  ae_threshold,
    input wire logic [THR_W:0]    wr_count,
    input wire logic [THR_W:0]    rd_count,
    input wire logic [THR_W:0]    data_count,
    input wire logic              almost_full,
    input wire logic              almost_empty,
    input wire logic              underflow
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    logic           push;
    logic           pop;
    logic [THR_W:0] cnt_exp;
    assign push    = s_arvalid & s_arready;
    assign pop     = m_arvalid & m_arready;
    assign cnt_exp = data_count + {{THR_W{1'b0}}, push} - {{THR_W{1'b0}}, pop};

    // ------------------------------------------------------------
    // counts and flags
    // ------------------------------------------------------------
    chk_wr_count_lag: assert property (
        wr_count == $past(data_count)) else $error("wr_count not one edge behind");
    chk_rd_count_lag: assert property (
        rd_count == $past(data_count)) else $error("rd_count not one edge behind");
    chk_count_step: assert property (
        1'b1 |=> data_count == $past(cnt_exp)) else $error("data_count step wrong");
    chk_af_level: assert property (
        almost_full == (data_count >= {1'b0, af_threshold})) else $error("almost_full wrong");
    chk_ae_level: assert property (
        almost_empty == (data_count <= {1'b0, ae_threshold})) else $error("almost_empty wrong");
    chk_no_underflow: assert property (
        !underflow) else $error("underflow raised");

    // ------------------------------------------------------------
    // handshakes
    // ------------------------------------------------------------
    chk_full_not_ready: assert property (
        data_count == 5'h10 |-> !s_arready) else $error("ready while full");
    chk_empty_not_valid: assert property (
        data_count == 5'h00 |-> !m_arvalid) else $error("valid while empty");
    chk_empty_forward: assert property (
        push && data_count == 5'h00 |=> m_arvalid && m_araddr == $past(s_araddr)
        && m_arprot == $past(s_arprot)) else $error("entry not forwarded");
    chk_down_hold: assert property (
        m_arvalid && !m_arready |=> m_arvalid && $stable(m_araddr) && $stable(m_arprot))
        else $error("downstream entry moved before ready");
    chk_up_hold: assert property (
        s_arvalid && !s_arready |=> s_arvalid && $stable(s_araddr) && $stable(s_arprot))
        else $error("upstream request dropped before ready");
    chk_refused_pop: assert property (
        m_arready && !m_arvalid && !push |=> $stable(data_count) && !m_arvalid)
        else $error("refused pop changed state");

    cov_pop:       cover property (pop);
    cov_full_wait: cover property (data_count == 5'h10 && s_arvalid);
    cov_af_rise:   cover property ($rose(almost_full));
endmodule

// ---- testbench/lite_read_addr_channel_fifo_tb.sv ----
`timescale 1ns/100ps
module lite_read_addr_channel_fifo_tb
    import lite_ar_pkg::*;
;
    logic        clk_sys_i;
    logic        arst_n_i;
    logic [7:0]  reg_addr_i;
    logic [31:0] reg_wdata_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [31:0] reg_rdata_o;
    logic        irq_o;
    logic [35:0] exp_q[$];
    logic [35:0] head;
    int          error_cnt;
    int          check_count;
    int          pop_cnt;

    lite_ar_if #(.AW(ADDR_W), .TW(THR_W)) lite_ar_if_inst ();
    lite_ar_fifo lite_ar_fifo_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .bus(lite_ar_if_inst));
    lite_ar_ctrl lite_ar_ctrl_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
        .bus(lite_ar_if_inst));
    lite_ar_asserts lite_ar_asserts_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .s_arvalid(lite_ar_if_inst.s_arvalid), .s_arready(lite_ar_if_inst.s_arready),
        .s_araddr(lite_ar_if_inst.s_araddr), .s_arprot(lite_ar_if_inst.s_arprot),
        .m_arvalid(lite_ar_if_inst.m_arvalid), .m_arready(lite_ar_if_inst.m_arready),
        .m_araddr(lite_ar_if_inst.m_araddr), .m_arprot(lite_ar_if_inst.m_arprot),
        .af_threshold(lite_ar_if_inst.af_threshold),
        .ae_threshold(lite_ar_if_inst.ae_threshold),
        .wr_count(lite_ar_if_inst.wr_count), .rd_count(lite_ar_if_inst.rd_count),
        .data_count(lite_ar_if_inst.data_count), .almost_full(lite_ar_if_inst.almost_full),
        .almost_empty(lite_ar_if_inst.almost_empty), .underflow(lite_ar_if_inst.underflow));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clk_sys_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(name, exp, reg_rdata_o);
    endtask

    // queue the entry first so the pop monitor always has it
    task automatic push(input logic [31:0] a, input logic [3:0] p, input bit wait_done);
        exp_q.push_back({p, a});
        reg_wr(REG_ADDR, a);
        reg_wr(REG_PROT, {28'h0, p});
        reg_wr(REG_PUSH, 32'h1);
        repeat (2) @(negedge clk_sys_i);
        for (int n = 0; n < 10 && wait_done && lite_ar_if_inst.s_arvalid !== 1'b0; n++)
            @(negedge clk_sys_i);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // downstream order monitor
    // ------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (arst_n_i && lite_ar_if_inst.m_arvalid && lite_ar_if_inst.m_arready) begin
            head = (exp_q.size() > 0) ? exp_q.pop_front() : 36'h0;
            pop_cnt++;
            chk("m_araddr", head[31:0], lite_ar_if_inst.m_araddr);
            chk("m_arprot", {28'h0, head[35:32]}, {28'h0, lite_ar_if_inst.m_arprot});
        end
    end

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    // hang guard: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        error_cnt++;
        $display("watchdog expired");
        tally_and_finish;
    end

    initial begin
        arst_n_i    = 1'b0;
        reg_addr_i  = 8'h00;
        reg_wdata_i = 32'h0;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        repeat (16) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        reg_rd(REG_STATUS, 32'h4, "status");
        reg_rd(8'hfc, 32'h0, "unmapped");
        reg_rd(REG_AF_THR, 32'(AF_THR_RST), "af_thr");
        reg_rd(REG_AE_THR, 32'(AE_THR_RST), "ae_thr");
        chk("s_arready", 32'h1, {31'h0, lite_ar_if_inst.s_arready});
        $display("test reset done");

        push(32'h1234_5678, 4'h5, 1'b1);
        chk("data_count", 32'h1, {27'h0, lite_ar_if_inst.data_count});
        chk("wr_count_lag", 32'h0, {27'h0, lite_ar_if_inst.wr_count});
        chk("rd_count_safe", 32'h0, {27'h0, lite_ar_if_inst.rd_count});
        chk("head_addr", 32'h1234_5678, lite_ar_if_inst.m_araddr);
        chk("irq_masked", 32'h0, {31'h0, irq_o});
        reg_rd(REG_IRQ_STAT, 32'h1, "irq_stat");
        chk("wr_count_one", 32'h1, {27'h0, lite_ar_if_inst.wr_count});
        chk("rd_count_one", 32'h1, {27'h0, lite_ar_if_inst.rd_count});
        reg_wr(REG_IRQ_EN, 32'hf);
        reg_rd(REG_IRQ_EN, 32'hf, "irq_en");
        repeat (2) @(negedge clk_sys_i);
        chk("irq_on", 32'h1, {31'h0, irq_o});
        reg_wr(REG_IRQ_CLR, 32'hf);
        repeat (2) @(negedge clk_sys_i);
        chk("irq_cleared", 32'h0, {31'h0, irq_o});
        $display("test push and interrupt done");

        for (int i = 1; i < 16; i++) push(32'h8000_0000 + i, i[3:0], 1'b1);
        chk("full_count", 32'h10, {27'h0, lite_ar_if_inst.data_count});
        chk("full_ready", 32'h0, {31'h0, lite_ar_if_inst.s_arready});
        chk("full_af", 32'h1, {31'h0, lite_ar_if_inst.almost_full});
        chk("full_ae", 32'h0, {31'h0, lite_ar_if_inst.almost_empty});
        reg_rd(REG_IRQ_STAT, 32'h5, "irq_af_rise");
        push(32'hcafe_0011, 4'ha, 1'b0);
        repeat (4) @(negedge clk_sys_i);
        chk("refused_count", 32'h10, {27'h0, lite_ar_if_inst.data_count});
        chk("held_valid", 32'h1, {31'h0, lite_ar_if_inst.s_arvalid});
        reg_wr(REG_ADDR, 32'hdead_beef);
        reg_rd(REG_ADDR, 32'hcafe_0011, "frozen_addr");
        reg_rd(REG_STATUS, 32'h3, "status_full");
        reg_rd(REG_COUNT, 32'h10, "count_full");
        $display("test fill done");

        reg_wr(REG_IRQ_CLR, 32'hf);
        reg_wr(REG_SINK, 32'h1);
        reg_wr(REG_SINK, 32'h0);
        repeat (6) @(negedge clk_sys_i);
        reg_wr(REG_SINK, 32'h1);
        reg_rd(REG_SINK, 32'h1, "sink");
        for (int n = 0; n < 200 && exp_q.size() != 0; n++) @(negedge clk_sys_i);
        repeat (4) @(negedge clk_sys_i);
        chk("pops", 32'd17, pop_cnt);
        chk("empty_count", 32'h0, {27'h0, lite_ar_if_inst.data_count});
        chk("rd_count", 32'h0, {27'h0, lite_ar_if_inst.rd_count});
        chk("wr_count", 32'h0, {27'h0, lite_ar_if_inst.wr_count});
        chk("empty_valid", 32'h0, {31'h0, lite_ar_if_inst.m_arvalid});
        chk("underflow", 32'h0, {31'h0, lite_ar_if_inst.underflow});
        chk("empty_ae", 32'h1, {31'h0, lite_ar_if_inst.almost_empty});
        reg_rd(REG_RX_ADDR, 32'hcafe_0011, "rx_addr");
        reg_rd(REG_RX_PROT, 32'ha, "rx_prot");
        chk("irq_recv", 32'h1, {31'h0, irq_o});
        $display("test drain done");
        tally_and_finish;
    end
endmodule
